/* src/bors_pkg.sv */
// Package for the brown-out reset sequencer
`default_nettype none
package bors_pkg;
   localparam int BORS_PLL_LOCK_BIT = 5;
   localparam int BORS_BOR_FLAG_BIT = 1;
   localparam int BORS_CLK_MHZ = 200;
   localparam int BORS_OST_CYCLES = 1024;
   localparam int BORS_POWERUP_TIMER_NS = 20000;
   localparam int BORS_POWERUP_TIMER_CYC = (BORS_POWERUP_TIMER_NS * BORS_CLK_MHZ) / 1000;
   localparam int BORS_FSCM_NS = 2000;
   localparam int BORS_FSCM_CYC = (BORS_FSCM_NS * BORS_CLK_MHZ + 999) / 1000;
   localparam int BORS_PULSE_CYC = 4;
   localparam logic [2:0] BORS_OSC_PRI = 3'h2;
   localparam logic [2:0] BORS_OSC_PRI_PLL = 3'h3;
   localparam logic [1:0] BORS_POSC_EC = 2'h0;
   localparam logic [1:0] BORS_POSC_OFF = 2'h3;

   typedef enum logic [1:0]
   {
      BORS_IDLE = 2'b00,
      BORS_PULSE = 2'b01,
      BORS_WAIT = 2'b10
   } bors_phase_t;

   typedef struct packed
   {
      logic [2:0] osc_select_cfg;
      logic [1:0] primary_osc_mode_cfg;
   } bors_cfg_t;

   typedef struct packed
   {
      bors_phase_t phase;
      logic [2:0] pulse_cnt;
      logic [23:0] delay_cnt;
      logic [15:0] ost_cnt;
      logic use_osc;
      logic use_pll;
      logic delay_done;
      logic clk_ok;
      logic brownout_reset;
      logic internal_reset;
      logic clk_gate_en;
      logic [2:0] clk_src;
      logic bor_flag;
   } bors_state_t;

   // Clock left running in reset so the rest of the chip can be reset synchronously
   localparam bors_state_t BORS_STATE_RST = '{
      phase: BORS_IDLE,
      pulse_cnt: 3'h0,
      delay_cnt: 24'h0,
      ost_cnt: 16'h0,
      use_osc: 1'b0,
      use_pll: 1'b0,
      delay_done: 1'b0,
      clk_ok: 1'b0,
      brownout_reset: 1'b0,
      internal_reset: 1'b0,
      clk_gate_en: 1'b1,
      clk_src: 3'h0,
      bor_flag: 1'b0
   };
endpackage : bors_pkg
`default_nettype wire

/* src/bors_sequencer.sv */
// Brown-out reset sequencer: reset pulse, clock qualification and delay
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Brown-out on core supply fires a reset pulse resetting the whole device.
// - Clock source is taken from oscillator-select and primary-mode configuration fields.
// - Oscillator mode starts the start-up timer; system clock gated until expiry.
// - With PLL, system clock stays gated until the lock bit reads one.
// - Power-up delay runs alongside clock start-up; reset held until it elapses.
// - Zero power-up delay with crystal uses the fail-safe monitor delay instead.
// - Brown-out status flag in the reset control bit is set after the event.
// - Detector stays active in Sleep and Idle; any dip resets the device.
module bors_sequencer
   import bors_pkg::*;
#(
   parameter int POWERUP_TIMER_CYC = BORS_POWERUP_TIMER_CYC,
   parameter int FSCM_CYC = BORS_FSCM_CYC,
   parameter int OST_CYC = BORS_OST_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic supply_below_thr,
   input wire logic sleep_mode,
   input wire logic idle_mode,
   input wire bors_cfg_t cfg,
   input wire logic powerup_timer_zero,
   input wire logic [7:0] osc_control_reg,
   input wire logic flag_clear,
   output logic brownout_reset,
   output logic internal_reset,
   output logic clk_gate_en,
   output logic [2:0] clk_src,
   output logic bor_flag
);
   bors_state_t s;
   bors_state_t next_s;
   logic pll_lock;
   logic crystal;

   function automatic logic bors_is_primary(input logic [2:0] sel, input logic [1:0] mode);
      return (sel == BORS_OSC_PRI || sel == BORS_OSC_PRI_PLL) && mode != BORS_POSC_OFF;
   endfunction : bors_is_primary

   // EC is an external clock, not a crystal
   function automatic logic bors_is_crystal(input logic [1:0] mode);
      return (mode != BORS_POSC_EC) && (mode != BORS_POSC_OFF);
   endfunction : bors_is_crystal

   function automatic logic [23:0] bors_delay_load(input logic zero, input logic xtal);
      if (zero && xtal)
         return 24'(FSCM_CYC);
      else if (zero)
         return 24'h0;
      else
         return 24'(POWERUP_TIMER_CYC);
   endfunction : bors_delay_load

   assign pll_lock = osc_control_reg[BORS_PLL_LOCK_BIT];
   assign crystal = bors_is_crystal(cfg.primary_osc_mode_cfg);

   always_comb
   begin
      next_s = s;
      // Sleep and idle deliberately not consulted; detector always live
      if (supply_below_thr)
      begin
         next_s.phase = BORS_PULSE;
         next_s.pulse_cnt = 3'h0;
         next_s.brownout_reset = 1'b1;
         next_s.internal_reset = 1'b1;
         next_s.clk_gate_en = 1'b0;
         next_s.clk_src = cfg.osc_select_cfg;
         next_s.use_osc = bors_is_primary(cfg.osc_select_cfg, cfg.primary_osc_mode_cfg);
         next_s.use_pll = (cfg.osc_select_cfg == BORS_OSC_PRI_PLL);
         next_s.delay_done = 1'b0;
         next_s.clk_ok = 1'b0;
         next_s.ost_cnt = 16'h0;
         next_s.delay_cnt = bors_delay_load(powerup_timer_zero, crystal);
         next_s.bor_flag = 1'b1;
      end
      else
      begin
         // Set wins over clear
         if (flag_clear)
            next_s.bor_flag = 1'b0;
         unique case (s.phase)
            BORS_IDLE:
            begin
            end
            BORS_PULSE:
            begin
               next_s.pulse_cnt = s.pulse_cnt + 3'h1;
               if (s.pulse_cnt == 3'(BORS_PULSE_CYC - 1))
               begin
                  next_s.brownout_reset = 1'b0;
                  next_s.phase = BORS_WAIT;
               end
            end
            BORS_WAIT:
            begin
               if (s.delay_cnt != 24'h0)
                  next_s.delay_cnt = s.delay_cnt - 24'h1;
               else
                  next_s.delay_done = 1'b1;
               if (s.use_osc && s.ost_cnt != 16'(OST_CYC))
                  next_s.ost_cnt = s.ost_cnt + 16'h1;
               if ((!s.use_osc || s.ost_cnt == 16'(OST_CYC)) && (!s.use_pll || pll_lock))
               begin
                  next_s.clk_ok = 1'b1;
                  next_s.clk_gate_en = 1'b1;
               end
               if (s.delay_done && s.clk_ok)
               begin
                  next_s.internal_reset = 1'b0;
                  next_s.phase = BORS_IDLE;
               end
            end
            default:
               next_s.phase = BORS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= BORS_STATE_RST;
      end
      else
         s <= next_s;
   end

   assign brownout_reset = s.brownout_reset;
   assign internal_reset = s.internal_reset;
   assign clk_gate_en = s.clk_gate_en;
   assign clk_src = s.clk_src;
   assign bor_flag = s.bor_flag;

   a_dip_pulses: assert property (@(posedge clk) disable iff (!rst_n)
      supply_below_thr |=> brownout_reset && internal_reset && !clk_gate_en)
      else $error("brown-out did not assert reset");
   a_flag_sets: assert property (@(posedge clk) disable iff (!rst_n)
      supply_below_thr |=> bor_flag)
      else $error("brown-out flag not set");
   a_src_taken: assert property (@(posedge clk) disable iff (!rst_n)
      supply_below_thr |=> clk_src == $past(cfg.osc_select_cfg))
      else $error("clock source not taken from config");
   a_sleep_live: assert property (@(posedge clk) disable iff (!rst_n)
      (supply_below_thr && (sleep_mode || idle_mode)) |=> internal_reset)
      else $error("detector inactive in low power");
   a_release_both: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(internal_reset) |-> $past(s.delay_done) && $past(s.clk_ok))
      else $error("reset released early");
   a_pll_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (s.phase == BORS_WAIT && s.use_pll && !pll_lock && !s.clk_ok) |=> !clk_gate_en)
      else $error("clock ungated before lock");
   a_ost_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (s.phase == BORS_WAIT && s.use_osc && s.ost_cnt != 16'(OST_CYC)) |=> !clk_gate_en)
      else $error("clock ungated before timer expiry");
   a_delay_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (s.phase == BORS_WAIT && s.delay_cnt != 24'h0) |=> internal_reset)
      else $error("reset released during delay");
   a_fscm_load: assert property (@(posedge clk) disable iff (!rst_n)
      (supply_below_thr && powerup_timer_zero && crystal) |=> s.delay_cnt == 24'(FSCM_CYC))
      else $error("fail-safe delay not applied");

   // Pulse, clock source, gate and delay checks
   a_pulse_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (s.phase == BORS_PULSE && s.pulse_cnt != 3'(BORS_PULSE_CYC - 1)) |=> brownout_reset)
      else $error("reset pulse ended early");
   a_pulse_end: assert property (@(posedge clk) disable iff (!rst_n)
      (!supply_below_thr && s.phase == BORS_PULSE && s.pulse_cnt == 3'(BORS_PULSE_CYC - 1))
      |=> !brownout_reset)
      else $error("reset pulse too long");
   a_pulse_inner: assert property (@(posedge clk) disable iff (!rst_n)
      brownout_reset |-> internal_reset)
      else $error("pulse without internal reset");
   a_src_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !supply_below_thr |=> clk_src == $past(clk_src))
      else $error("clock source changed without brown-out");
   a_pll_pick: assert property (@(posedge clk) disable iff (!rst_n)
      (supply_below_thr && cfg.osc_select_cfg == BORS_OSC_PRI_PLL) |=> s.use_pll)
      else $error("pll source not taken");
   a_gate_low: assert property (@(posedge clk) disable iff (!rst_n)
      brownout_reset |-> !clk_gate_en)
      else $error("clock running during pulse");
   a_gate_on: assert property (@(posedge clk) disable iff (!rst_n)
      (s.phase == BORS_WAIT && !supply_below_thr && (!s.use_osc || s.ost_cnt == 16'(OST_CYC))
      && (!s.use_pll || pll_lock)) |=> clk_gate_en)
      else $error("clock not enabled once qualified");
   a_ost_count: assert property (@(posedge clk) disable iff (!rst_n)
      (!supply_below_thr && s.phase == BORS_WAIT && s.use_osc && s.ost_cnt != 16'(OST_CYC))
      |=> s.ost_cnt == $past(s.ost_cnt) + 16'h1)
      else $error("start-up timer stalled");
   a_powerup_timer_load: assert property (@(posedge clk) disable iff (!rst_n)
      (supply_below_thr && !powerup_timer_zero) |=> s.delay_cnt == 24'(POWERUP_TIMER_CYC))
      else $error("power-up delay not loaded");
   a_delay_count: assert property (@(posedge clk) disable iff (!rst_n)
      (!supply_below_thr && s.phase == BORS_WAIT && s.delay_cnt != 24'h0)
      |=> s.delay_cnt == $past(s.delay_cnt) - 24'h1)
      else $error("power-up delay stalled");
   a_wait_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (s.phase == BORS_WAIT && !s.delay_done) |-> internal_reset)
      else $error("reset free before delay done");
   a_ec_nodelay: assert property (@(posedge clk) disable iff (!rst_n)
      (supply_below_thr && powerup_timer_zero && !crystal) |=> s.delay_cnt == 24'h0)
      else $error("zero delay not honoured");

   // Status flag and release
   a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      (bor_flag && !flag_clear) |=> bor_flag)
      else $error("brown-out flag lost");
   a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (flag_clear && !supply_below_thr) |=> !bor_flag)
      else $error("brown-out flag not cleared");
   a_sleep_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (supply_below_thr && (sleep_mode || idle_mode)) |=> bor_flag && brownout_reset)
      else $error("low power dip not recorded");
   a_idle_free: assert property (@(posedge clk) disable iff (!rst_n)
      (s.phase == BORS_IDLE && !supply_below_thr) |=> !internal_reset && !brownout_reset)
      else $error("reset held while idle");
   a_gate_release: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(internal_reset) |-> clk_gate_en)
      else $error("reset released with clock gated");
endmodule : bors_sequencer
`default_nettype wire

/* dv/bors_sequencer_tb.sv */
// Self-checking testbench for the brown-out reset sequencer
`timescale 1ns/1ps
`default_nettype none
module bors_sequencer_tb;
   import bors_pkg::*;
   // Delay kept longest so the three release paths give distinct counts
   localparam int PW = 20;
   localparam int FS = 12;
   localparam int OS = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic below = 1'b0;
   logic sleep_m = 1'b0;
   logic idle_m = 1'b0;
   bors_cfg_t cfg = '0;
   logic pz = 1'b0;
   logic [7:0] oscr = 8'h00;
   logic fclr = 1'b0;
   logic bres;
   logic ires;
   logic gate;
   logic flag;
   logic [2:0] src;
   int fail_count = 0;
   int check_count = 0;
   int n;
   bors_sequencer #(.POWERUP_TIMER_CYC(PW), .FSCM_CYC(FS), .OST_CYC(OS)) uut (.clk(clk), .rst_n(rst_n),
      .supply_below_thr(below), .sleep_mode(sleep_m), .idle_mode(idle_m), .cfg(cfg),
      .powerup_timer_zero(pz), .osc_control_reg(oscr), .flag_clear(fclr), .brownout_reset(bres),
      .internal_reset(ires), .clk_gate_en(gate), .clk_src(src), .bor_flag(flag));
   initial forever #2.5 clk = ~clk;
   task stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   task chk(input string name, input logic [2:0] exp, input logic [2:0] got);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk
   // One-cycle dip, then count cycles until the internal reset lets go
   task dip(input logic [2:0] sel, input logic [1:0] mode, input logic zero, input logic clr,
      input int lock_at, output int cyc);
      @(posedge clk);
      cfg <= '{sel, mode};
      pz <= zero;
      below <= 1'b1;
      fclr <= clr;
      @(posedge clk);
      below <= 1'b0;
      fclr <= 1'b0;
      #1;
      chk("brownout_reset", 3'h1, bres);
      chk("clk_gate_en", 3'h0, gate);
      chk("bor_flag", 3'h1, flag);
      chk("clk_src", sel, src);
      cyc = 0;
      while (ires === 1'b1 && cyc < 300)
      begin
         @(posedge clk);
         if (cyc + 1 == lock_at)
            oscr <= 8'h20;
         #1;
         cyc++;
         if (cyc == 3)
            chk("pulse_held", 3'h1, bres);
         if (cyc == 6)
            chk("pulse_ended", 3'h0, bres);
      end
      if (cyc >= 300)
      begin
         fail_count++;
         $display("[ERR] release expected below 300 seen timeout");
         stop_test();
      end
      chk("gate_at_release", 3'h1, gate);
   endtask : dip
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("reset_gate", 3'h1, gate);
      chk("reset_flag", 3'h0, flag);
      @(posedge clk);
      sleep_m <= 1'b1;
      idle_m <= 1'b1;
      dip(3'h2, 2'h1, 1'b0, 1'b0, 0, n);
      chk("powerup_timer_wait", 3'h1, 3'(n >= PW));
      $display("test sleep_idle_powerup_timer done");
      sleep_m <= 1'b0;
      idle_m <= 1'b0;
      dip(3'h3, 2'h1, 1'b0, 1'b0, 60, n);
      chk("pll_wait", 3'h1, 3'(n >= 60 && n < 64));
      $display("test pll_lock done");
      dip(3'h2, 2'h1, 1'b1, 1'b0, 0, n);
      chk("fscm_wait", 3'h1, 3'(n >= FS && n < PW));
      dip(3'h2, BORS_POSC_EC, 1'b1, 1'b0, 0, n);
      chk("ec_no_fscm", 3'h1, 3'(n < FS));
      $display("test zero_delay done");
      @(posedge clk);
      fclr <= 1'b1;
      @(posedge clk);
      fclr <= 1'b0;
      @(posedge clk);
      #1;
      chk("flag_cleared", 3'h0, flag);
      dip(3'h0, BORS_POSC_OFF, 1'b0, 1'b1, 0, n);
      $display("test flag done");
      stop_test();
   end
endmodule : bors_sequencer_tb
`default_nettype wire
